// file: logic/host_port_consts.svh
// Timing counts, field positions and reset values for the host port controller
// Operation
// - Access codes: control, address 10b, data autoincrement 01b, data plain.
// - Host holds port select low throughout each access it performs.
// - Direction sampled at strobe fall; high requests read, low requests write.
// - Halfword id low for first halfword, high for second halfword.
// - Address strobe is unused and held permanently high by the host.
// - Processor raises host interrupt; host acknowledges by writing 1 to the bit.
// - One 16-bit two-way bus carries address and data halfwords.
// - Wait high means hold the cycle; host completes only after it goes low.
// - Host loads only word-aligned byte addresses, low two bits zero.
// - Host reloads address registers after each change of the split-address bit.
// - Combined mode: host reloads addresses whenever data direction changes.
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

`define CLK_PERIOD_NS    25
`define SETUP_NS         50
`define STROBE_LOW_NS    75
`define HOLD_NS          25
`define SETUP_CYC        ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CYC          ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC         ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define SPLIT_MODE_BIT   3
`define SPLIT_MODE_RESET 1'b0
`define ALIGN_MASK       2'h3

`endif

// file: logic/host_port_pkg.sv
// Types shared by the host port controller modules
package host_port_pkg;

   typedef enum logic [1:0] {
      ACC_CONTROL  = 2'b00,
      ACC_DATA_INC = 2'b01,
      ACC_ADDR     = 2'b10,
      ACC_DATA     = 2'b11
   } access_e;

   typedef enum logic [1:0] {
      M_IDLE   = 2'b00,
      M_FIRST  = 2'b01,
      M_SECOND = 2'b10
   } main_e;

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_SETUP = 2'b01,
      PH_LOW   = 2'b10,
      PH_HOLD  = 2'b11
   } phase_e;

endpackage

// file: logic/halfword_if.sv
// Link between the transfer sequencer and the halfword strobe engine
`timescale 1ns/1ps
interface halfword_if;
   logic        start;
   logic        writeDir;
   logic [15:0] wrHalf;
   logic        done;
   logic [15:0] rdHalf;
   logic        strobeN;
   logic        busOe;
   logic [15:0] busOut;

   modport phase (input start, writeDir, wrHalf, output done, rdHalf, strobeN, busOe, busOut);
   modport ctrl  (output start, writeDir, wrHalf, input done, rdHalf, strobeN, busOe, busOut);
endinterface

// file: logic/halfword_strobe.sv
// One halfword strobe cycle: setup, strobe low until wait drops, hold
`timescale 1ns/1ps
`include "host_port_consts.svh"
module halfword_strobe #(
   parameter int SETUP_CYC = `SETUP_CYC,
   parameter int LOW_CYC   = `LOW_CYC,
   parameter int HOLD_CYC  = `HOLD_CYC
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        waitSync,
   input  wire logic [15:0] busSync,
   halfword_if.phase        hw
);

   // Counters are four bits; the low phase must outlast the wait synchroniser
   if (SETUP_CYC < 1 || SETUP_CYC > 15 || LOW_CYC < 3 || LOW_CYC > 15 ||
       HOLD_CYC < 1 || HOLD_CYC > 15) begin : g_bad_counts
      $error("halfword_strobe: cycle counts out of range");
   end

   host_port_pkg::phase_e state_reg;
   logic [3:0]            count_reg;
   wire                   countDone = (count_reg == 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= host_port_pkg::PH_IDLE;
         count_reg  <= 4'h0;
         hw.done    <= 1'b0;
         hw.rdHalf  <= 16'h0000;
         hw.strobeN <= 1'b1;
         hw.busOe   <= 1'b0;
         hw.busOut  <= 16'h0000;
      end else begin
         hw.done <= 1'b0;
         unique case (state_reg)
            host_port_pkg::PH_IDLE: begin
               if (hw.start) begin
                  // Drive write data ahead of the strobe; reads leave the bus to the port
                  hw.busOe  <= hw.writeDir;
                  hw.busOut <= hw.wrHalf;
                  count_reg <= 4'(SETUP_CYC - 1);
                  state_reg <= host_port_pkg::PH_SETUP;
               end
            end
            host_port_pkg::PH_SETUP: begin
               if (countDone) begin
                  hw.strobeN <= 1'b0;
                  count_reg  <= 4'(LOW_CYC - 1);
                  state_reg  <= host_port_pkg::PH_LOW;
               end else begin
                  count_reg <= count_reg - 4'h1;
               end
            end
            host_port_pkg::PH_LOW: begin
               // Synced wait lags the pin, so it is ignored for the first cycles
               if (!countDone) begin
                  count_reg <= count_reg - 4'h1;
               end else if (!waitSync) begin
                  hw.strobeN <= 1'b1;
                  hw.rdHalf  <= busSync;
                  count_reg  <= 4'(HOLD_CYC - 1);
                  state_reg  <= host_port_pkg::PH_HOLD;
               end
            end
            host_port_pkg::PH_HOLD: begin
               if (countDone) begin
                  hw.busOe  <= 1'b0;
                  hw.done   <= 1'b1;
                  state_reg <= host_port_pkg::PH_IDLE;
               end else begin
                  count_reg <= count_reg - 4'h1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   wait_respected_a: assert property ($rose(hw.strobeN) |-> !$past(waitSync))
      else $error("strobe released while port still asked to wait");

   strobe_min_low_a: assert property ($fell(hw.strobeN) |-> !hw.strobeN [*3])
      else $error("strobe low shorter than three cycles");

   write_data_held_a: assert property (
         $rose(hw.strobeN) && $past(hw.busOe) |-> hw.busOe)
      else $error("write data dropped at strobe rise");

   data_before_strobe_a: assert property ($fell(hw.strobeN) |-> $stable(hw.busOe))
      else $error("bus drive changed at strobe fall");

endmodule

// file: logic/host_port_master.sv
// Host side controller driving the multiplexed 16-bit parallel port pins
`timescale 1ns/1ps
`include "host_port_consts.svh"
module host_port_master #(
   parameter int SETUP_CYC = `SETUP_CYC,
   parameter int LOW_CYC   = `LOW_CYC,
   parameter int HOLD_CYC  = `HOLD_CYC
) (
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   input  wire logic                   reqValid,
   input  host_port_pkg::access_e      reqAccess,
   input  wire logic                   reqRead,
   input  wire logic [31:0]            reqWord,
   output logic                        reqReady,
   output logic                        respValid,
   output logic                        respError,
   output logic [31:0]                 respWord,
   output logic                        splitMode,
   output logic                        irqActive,
   output logic [1:0]                  accessSelect,
   output logic                        portSelectN,
   output logic                        hostDirection,
   output logic                        halfwordId,
   output logic                        addressStrobeN,
   output logic                        dataStrobeAN,
   output logic                        dataStrobeBN,
   output logic [15:0]                 hostBusOut,
   output logic                        hostBusOe,
   input  wire logic [15:0]            hostBusIn,
   input  wire logic                   hostWait,
   input  wire logic                   hostIrqN
);

   function automatic logic isData(input host_port_pkg::access_e a);
      isData = (a == host_port_pkg::ACC_DATA_INC) || (a == host_port_pkg::ACC_DATA);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [15:0] busMeta_reg;
   logic [15:0] busSync_reg;
   logic        waitMeta_reg;
   logic        waitSync_reg;
   logic        irqMeta_reg;
   logic        irqSync_reg;
   logic        irqActive_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busMeta_reg   <= 16'h0000;
         busSync_reg   <= 16'h0000;
         waitMeta_reg  <= 1'b1;
         waitSync_reg  <= 1'b1;
         irqMeta_reg   <= 1'b1;
         irqSync_reg   <= 1'b1;
         irqActive_reg <= 1'b0;
      end else begin
         busMeta_reg   <= hostBusIn;
         busSync_reg   <= busMeta_reg;
         waitMeta_reg  <= hostWait;
         waitSync_reg  <= waitMeta_reg;
         irqMeta_reg   <= hostIrqN;
         irqSync_reg   <= irqMeta_reg;
         // Pin low means the interrupt bit is set; acknowledge is a control write by the user
         irqActive_reg <= !irqSync_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Halfword engine
   halfword_if hw ();

   halfword_strobe #(
      .SETUP_CYC (SETUP_CYC),
      .LOW_CYC   (LOW_CYC),
      .HOLD_CYC  (HOLD_CYC)
   ) strobeEngine (
      .clock    (clock),
      .arst_n   (arst_n),
      .waitSync (waitSync_reg),
      .busSync  (busSync_reg),
      .hw       (hw.phase)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Request decode and refusal checks
   host_port_pkg::main_e state_reg;
   logic                 reqReady_reg;
   logic                 splitMode_reg;
   logic                 reloadNeeded_reg;
   logic                 dirKnown_reg;
   logic                 lastRead_reg;
   logic [31:0]          word_reg;

   wire accept       = reqValid && reqReady_reg;
   wire ctrlWrite    = (reqAccess == host_port_pkg::ACC_CONTROL) && !reqRead;
   wire addrWrite    = (reqAccess == host_port_pkg::ACC_ADDR) && !reqRead;
   wire dataAccess   = isData(reqAccess);
   wire unaligned    = addrWrite && ((reqWord[1:0] & `ALIGN_MASK) != 2'h0);
   wire dirConflict  = dataAccess && (reloadNeeded_reg ||
                       (!splitMode_reg && dirKnown_reg && (lastRead_reg != reqRead)));
   wire refuse       = unaligned || dirConflict;
   wire launch       = accept && !refuse;
   wire splitChanges = ctrlWrite && (reqWord[`SPLIT_MODE_BIT] != splitMode_reg);

   // Track what the port's address registers were last loaded for
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         splitMode_reg    <= `SPLIT_MODE_RESET;
         reloadNeeded_reg <= 1'b0;
         dirKnown_reg     <= 1'b0;
         lastRead_reg     <= 1'b0;
      end else if (launch) begin
         if (ctrlWrite) begin
            splitMode_reg <= reqWord[`SPLIT_MODE_BIT];
         end
         if (splitChanges) begin
            reloadNeeded_reg <= 1'b1;
            dirKnown_reg     <= 1'b0;
         end else if (addrWrite) begin
            reloadNeeded_reg <= 1'b0;
            dirKnown_reg     <= 1'b0;
         end else if (dataAccess) begin
            dirKnown_reg <= 1'b1;
            lastRead_reg <= reqRead;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= host_port_pkg::M_IDLE;
         reqReady_reg  <= 1'b1;
         respValid     <= 1'b0;
         respError     <= 1'b0;
         respWord      <= 32'h0000_0000;
         word_reg      <= 32'h0000_0000;
         accessSelect  <= 2'h0;
         portSelectN   <= 1'b1;
         hostDirection <= 1'b1;
         halfwordId    <= 1'b0;
         hw.start      <= 1'b0;
         hw.wrHalf     <= 16'h0000;
      end else begin
         respValid <= 1'b0;
         respError <= 1'b0;
         hw.start  <= 1'b0;
         unique case (state_reg)
            host_port_pkg::M_IDLE: begin
               if (accept && refuse) begin
                  respValid <= 1'b1;
                  respError <= 1'b1;
               end else if (launch) begin
                  // Controls settle during the engine's setup cycles before the strobe
                  reqReady_reg  <= 1'b0;
                  portSelectN   <= 1'b0;
                  accessSelect  <= reqAccess;
                  hostDirection <= reqRead;
                  halfwordId    <= 1'b0;
                  word_reg      <= reqWord;
                  hw.wrHalf     <= reqWord[15:0];
                  hw.start      <= 1'b1;
                  state_reg     <= host_port_pkg::M_FIRST;
               end
            end
            host_port_pkg::M_FIRST: begin
               if (hw.done) begin
                  respWord[15:0] <= hw.rdHalf;
                  halfwordId     <= 1'b1;
                  hw.wrHalf      <= word_reg[31:16];
                  hw.start       <= 1'b1;
                  state_reg      <= host_port_pkg::M_SECOND;
               end
            end
            host_port_pkg::M_SECOND: begin
               if (hw.done) begin
                  // Address advance on the port happens at the second halfword's strobe rise, before this done
                  respWord[31:16] <= hw.rdHalf;
                  respValid       <= 1'b1;
                  reqReady_reg    <= 1'b1;
                  portSelectN     <= 1'b1;
                  state_reg       <= host_port_pkg::M_IDLE;
               end
            end
         endcase
      end
   end

   // Strobe B and address strobe are parked; only strobe A is used
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addressStrobeN <= 1'b1;
         dataStrobeBN   <= 1'b1;
      end else begin
         addressStrobeN <= 1'b1;
         dataStrobeBN   <= 1'b1;
      end
   end

   assign hw.writeDir  = !hostDirection;
   assign reqReady     = reqReady_reg;
   assign splitMode    = splitMode_reg;
   assign irqActive    = irqActive_reg;
   assign dataStrobeAN = hw.strobeN;
   assign hostBusOut   = hw.busOut;
   assign hostBusOe    = hw.busOe;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence strobeFalls;
      $fell(dataStrobeAN);
   endsequence

   sequence controlsSteady;
      $stable(accessSelect) && $stable(hostDirection) && $stable(halfwordId) && !portSelectN;
   endsequence

   select_during_strobe_a: assert property (!dataStrobeAN |-> !portSelectN)
      else $error("strobe active while port deselected");

   controls_settled_a: assert property (strobeFalls |-> controlsSteady)
      else $error("controls changed at strobe fall");

   no_drive_on_read_a: assert property (hostBusOe |-> !hostDirection)
      else $error("host drives bus during a read");

   first_half_low_a: assert property (
         state_reg == host_port_pkg::M_FIRST |-> !halfwordId)
      else $error("halfword id high in first halfword");

   second_half_high_a: assert property (
         state_reg == host_port_pkg::M_SECOND |-> halfwordId)
      else $error("halfword id low in second halfword");

   unaligned_refused_a: assert property (
         accept && unaligned |=> respError && portSelectN)
      else $error("unaligned address was sent");

   dir_change_refused_a: assert property (
         accept && dataAccess && !splitMode_reg && dirKnown_reg && lastRead_reg != reqRead
         |=> respValid && respError)
      else $error("direction change without reload was sent");

   addr_strobe_high_a: assert property (addressStrobeN && dataStrobeBN)
      else $error("parked strobe driven low");

endmodule

// file: verification/port_device_model.sv
// Behavioural device on the far side of the host port
`timescale 1ns/1ps
module port_device_model #(
   parameter int SEL_BIT = 4,
   parameter int IRQ_BIT = 1
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [1:0]  accessSelect,
   input  wire logic        portSelectN,
   input  wire logic        hostDirection,
   input  wire logic        halfwordId,
   input  wire logic        addressStrobeN,
   input  wire logic        dataStrobeAN,
   input  wire logic        dataStrobeBN,
   input  wire logic [15:0] hostBusOut,
   input  wire logic        hostBusOe,
   input  wire logic        irqRaise,
   input  wire logic [2:0]  waitCyc,
   output logic [15:0]      hostBusIn,
   output logic             hostWait,
   output logic             hostIrqN,
   output logic             protoErr
);
   logic [31:0] rdAddr, wrAddr, word;
   logic [31:0] mem [logic [31:0]];
   logic [15:0] lowHalf, rdHalf;
   logic [1:0]  acc;
   logic [2:0]  cnt;
   logic        dir, split, sel, irq, expHw;
   wire         strobeN  = portSelectN | (dataStrobeAN ~^ dataStrobeBN);
   wire         driving  = !strobeN && dir;
   wire  [31:0] ctrlWord = (32'(split) << 3) | (32'(sel) << SEL_BIT) | (32'(irq) << IRQ_BIT);
   // Released bus shows the inverse so a stale value never passes
   assign hostBusIn = driving ? rdHalf : ~rdHalf;
   assign hostWait  = !strobeN && (cnt < waitCyc);
   assign hostIrqN  = !irq;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) cnt <= 3'h0;
      else if (strobeN) cnt <= 3'h0;
      else if (cnt < waitCyc) cnt <= cnt + 3'h1;
   end
   always @(posedge clock) begin
      if (!arst_n) begin
         {rdAddr, wrAddr, word, lowHalf, rdHalf} = '0;
         {acc, dir, split, sel, irq, expHw, protoErr} = '0;
      end
      else if (irqRaise) irq <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge strobeN) begin
      acc = accessSelect;
      dir = hostDirection;
      if (halfwordId !== expHw || addressStrobeN !== 1'b1) protoErr = 1'b1;
      if (dir && !halfwordId) begin
         case (acc)
            2'b00: word = ctrlWord;
            2'b10: word = (split && !sel) ? wrAddr : rdAddr;
            default: word = mem.exists(rdAddr) ? mem[rdAddr] : ~rdAddr;
         endcase
      end
      rdHalf = halfwordId ? word[31:16] : word[15:0];
   end
   always @(posedge strobeN) begin
      if (hostBusOe && dir) protoErr = 1'b1;
      // Wait counter still holds its value here, so an early release shows
      if (cnt < waitCyc) protoErr = 1'b1;
      if (!expHw) lowHalf = hostBusOut;
      else if (!dir) begin
         word = {hostBusOut, lowHalf};
         case (acc)
            2'b00: begin
               split = word[3];
               sel = word[SEL_BIT];
               if (word[IRQ_BIT]) irq = 1'b0;
            end
            2'b10: begin
               if (word[1:0] != 2'h0) protoErr = 1'b1;
               if (!split || sel) rdAddr = word;
               if (!split || !sel) wrAddr = word;
            end
            default: mem[wrAddr] = word;
         endcase
      end
      if (expHw && acc == 2'b01) begin
         if (dir || !split) rdAddr += 32'h4;
         if (!dir || !split) wrAddr += 32'h4;
      end
      expHw = !expHw;
   end
endmodule

// file: verification/host_parallel_port_addressing_tb_top.sv
// Self-checking testbench for the host port controller
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin nChecks++; if ((got) !== (exp)) begin numErrors++; \
   $display("unexpected at %0t ns: %s", $time, msg); end end
module host_parallel_port_addressing_tb_top;
   localparam int SEL_BIT = 4;
   localparam int IRQ_BIT = 1;
   localparam host_port_pkg::access_e CTL = host_port_pkg::ACC_CONTROL;
   localparam host_port_pkg::access_e INC = host_port_pkg::ACC_DATA_INC;
   localparam host_port_pkg::access_e ADR = host_port_pkg::ACC_ADDR;
   localparam host_port_pkg::access_e DAT = host_port_pkg::ACC_DATA;
   logic                   clock = 1'b0;
   logic                   arst_n = 1'b0;
   logic                   reqValid = 1'b0;
   logic                   reqRead = 1'b0;
   logic                   irqRaise = 1'b0;
   host_port_pkg::access_e reqAccess = CTL;
   logic [31:0]            reqWord = 32'h0;
   logic [2:0]             waitCyc = 3'h0;
   logic                   reqReady, respValid, respError, splitMode, irqActive, portSelectN;
   logic                   hostDirection, halfwordId, addressStrobeN, dataStrobeAN;
   logic                   dataStrobeBN, hostBusOe, hostWait, hostIrqN, protoErr, gotErr;
   logic [1:0]             accessSelect;
   logic [15:0]            hostBusOut, hostBusIn;
   logic [31:0]            respWord, got, expRd, expWr, base;
   logic [31:0]            expMem [logic [31:0]];
   logic                   split, sel, irqExp;
   int                     numErrors = 0;
   int                     nChecks = 0;
   int                     seed = 59;

   host_port_master u_host_port_master (.clock, .arst_n, .reqValid, .reqAccess, .reqRead,
      .reqWord, .reqReady, .respValid, .respError, .respWord, .splitMode, .irqActive,
      .accessSelect, .portSelectN, .hostDirection, .halfwordId, .addressStrobeN,
      .dataStrobeAN, .dataStrobeBN, .hostBusOut, .hostBusOe, .hostBusIn, .hostWait, .hostIrqN);
   port_device_model #(.SEL_BIT(SEL_BIT), .IRQ_BIT(IRQ_BIT)) u_port_device_model (.clock,
      .arst_n, .accessSelect, .portSelectN, .hostDirection, .halfwordId, .addressStrobeN,
      .dataStrobeAN, .dataStrobeBN, .hostBusOut, .hostBusOe, .irqRaise, .waitCyc, .hostBusIn,
      .hostWait, .hostIrqN, .protoErr);

   initial begin
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d, errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Control word as the port reports it
   function automatic logic [31:0] expCtrl(input logic s, input logic q, input logic i);
      expCtrl = (32'(s) << 3) | (32'(q) << SEL_BIT) | (32'(i) << IRQ_BIT);
   endfunction

   task automatic issue(input host_port_pkg::access_e acc, input logic rd, input logic [31:0] w);
      int n;
      n = 0;
      @(posedge clock);
      reqValid <= 1'b1;
      reqAccess <= acc;
      reqRead <= rd;
      reqWord <= w;
      waitCyc <= 3'($random(seed));
      @(negedge clock);
      while (reqReady !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      reqValid <= 1'b0;
      @(negedge clock);
      while (respValid !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      `CHK(n < 400, 1'b1, "no response")
      gotErr = respError;
      got = respWord;
   endtask

   // Expected state is tracked here, independent of the device model
   task automatic xfer(input host_port_pkg::access_e acc, input logic rd, input logic [31:0] w,
                       input logic refuse);
      logic [31:0] e;
      issue(acc, rd, w);
      `CHK(gotErr, refuse, "refusal flag")
      if (!refuse) begin
         e = rd ? expRd : expWr;
         if (acc == CTL && rd)
            `CHK(got, expCtrl(split, sel, irqExp), "ctrl")
         else if (acc == CTL) begin
            split = w[3];
            sel = w[SEL_BIT];
            if (w[IRQ_BIT]) irqExp = 1'b0;
         end
         else if (acc == ADR && rd)
            `CHK(got, (split && !sel) ? expWr : expRd, "address read")
         else if (acc == ADR) begin
            if (!split || sel) expRd = w;
            if (!split || !sel) expWr = w;
         end
         else if (rd)
            `CHK(got, expMem[e], "read data")
         else
            expMem[e] = w;
         if (acc == INC && (rd || !split)) expRd += 32'h4;
         if (acc == INC && (!rd || !split)) expWr += 32'h4;
      end
      `CHK(u_port_device_model.rdAddr, expRd, "read address")
      `CHK(u_port_device_model.wrAddr, expWr, "write address")
      `CHK(splitMode, split, "split mode")
      `CHK(protoErr, 1'b0, "pin protocol")
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {expRd, expWr, split, sel, irqExp} = '0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      `CHK({reqReady, portSelectN, hostBusOe}, 3'h6, "reset")
      `CHK({addressStrobeN, dataStrobeBN}, 2'h3, "parked strobes")
      base = 32'($random(seed)) & 32'h0000_fff0;
      xfer(CTL, 1'b0, 32'h0, 1'b0);
      xfer(ADR, 1'b0, base | 32'h2, 1'b1);
      xfer(ADR, 1'b0, base, 1'b0);
      xfer(ADR, 1'b1, 32'h0, 1'b0);
      for (int i = 0; i < 4; i++) xfer(INC, 1'b0, 32'($random(seed)), 1'b0);
      xfer(DAT, 1'b0, 32'($random(seed)), 1'b0);
      xfer(ADR, 1'b0, base, 1'b0);
      for (int i = 0; i < 4; i++) xfer(INC, 1'b1, 32'h0, 1'b0);
      xfer(INC, 1'b0, 32'h1, 1'b1);
      xfer(CTL, 1'b0, 32'h8 | (32'h1 << SEL_BIT), 1'b0);
      xfer(DAT, 1'b1, 32'h0, 1'b1);
      xfer(ADR, 1'b0, base, 1'b0);
      xfer(CTL, 1'b0, 32'h8, 1'b0);
      xfer(ADR, 1'b0, base + 32'h40, 1'b0);
      xfer(ADR, 1'b1, 32'h0, 1'b0);
      xfer(INC, 1'b0, 32'($random(seed)), 1'b0);
      xfer(INC, 1'b1, 32'h0, 1'b0);
      xfer(DAT, 1'b1, 32'h0, 1'b0);
      @(posedge clock);
      irqRaise <= 1'b1;
      irqExp = 1'b1;
      @(posedge clock);
      irqRaise <= 1'b0;
      repeat (6) @(negedge clock);
      `CHK(irqActive, 1'b1, "irq raise")
      xfer(CTL, 1'b1, 32'h0, 1'b0);
      xfer(CTL, 1'b0, 32'h8 | (32'h1 << IRQ_BIT), 1'b0);
      repeat (6) @(negedge clock);
      `CHK(irqActive, 1'b0, "irq ack")
      give_verdict;
   end

   // A hung handshake ends the run here
   initial begin
      #500000;
      numErrors++;
      give_verdict;
   end
endmodule
